/* File: core/brxe_pkg.sv */
// Constants, types and behaviour summary for the bidirectional reset and extension bus enable block
// Function
// - Writes to bidir_reset_enable are ignored after end_of_init_instruction until next reset.
// - Any reset clears bidir_reset_enable; software must set it again.
// - With bidirectional reset active every reset is flagged as long hardware reset.
// - With bidirectional reset active port_zero configuration is sampled on any reset.
// - Bootstrap loader is entered when boot_select_input samples low during such reset.
// - A short external hardware reset is stretched to the full internal sequence.
// - Extension RAM and CAN are enabled only while xperipheral_enable is set.
// - Disabled extension modules decode no addresses and claim no port pins.
// - CAN lines route to port_four or port_eight by software-selected assignment.
// - With bidirectional reset enabled the reset pin is driven low for the sequence.
// - reset_indication_output stays low from any reset until end_of_init_instruction.
package brxe_pkg;

  // Register byte offsets
  localparam logic [7:0] SYS_CFG_OFS = 8'h00;
  localparam logic [7:0] CAN_CFG_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // system_config_register fields
  localparam int BIDIR_EN_BIT = 1;
  localparam int XPERIPHERAL_ENABLE_BIT = 2;
  localparam logic [31:0] SYS_CFG_RESET = 32'h0000_0000;
  // CAN pin assignment field: 0 port_four, 1 port_eight
  localparam int CAN_SEL_BIT = 0;

  // Status register fields
  localparam int ST_LONG_HW_BIT = 0;
  localparam int ST_SHORT_HW_BIT = 1;
  localparam int ST_SW_BIT = 2;
  localparam int ST_WDT_BIT = 3;
  localparam int ST_BOOT_BIT = 4;
  localparam int ST_INIT_DONE_BIT = 5;
  localparam int ST_P0_LSB = 16;
  localparam int BOOT_SEL_BIT = 4;

  // Extension bus address windows
  localparam logic [23:0] EXTENSION_RAM_BASE = 24'h00e000;
  localparam logic [23:0] EXTENSION_RAM_MASK = 24'hfff800;
  localparam logic [23:0] CAN_BASE = 24'h00ef00;
  localparam logic [23:0] CAN_MASK = 24'hffff00;

  // Internal reset sequence timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RESET_SEQ_NS = 5120;
  localparam int RESET_SEQ_CYC = (RESET_SEQ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SEQ_CNT_W = $clog2(RESET_SEQ_CYC + 1);
  // Sync delay on the pin input; our own release is masked this long
  localparam int PIN_MASK_CYC = 3;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_HOLD} brxe_seq_e;

  typedef enum logic [1:0] {SRC_HW, SRC_SW, SRC_WDT} brxe_src_e;

  typedef struct packed {
    logic [15:0] portZero;
    logic initDone;
    logic bootMode;
    logic wdt;
    logic sw;
    logic shortHw;
    logic longHw;
  } brxe_flags_s;

endpackage : brxe_pkg

/* File: core/brxe_top.sv */
// Reset sequencer with bidirectional reset pin, extension bus enables and CAN pin routing
`timescale 1ns/100ps
`default_nettype none
module brxe_top
  import brxe_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  // Classic Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  // Reset pin, open drain
  input wire logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOe_n,
  output logic resetIndOut_n,
  output logic sysReset_n,
  // Core reset sources and end of init
  input wire logic swResetReq,
  input wire logic wdtResetReq,
  input wire logic endOfInitExec,
  // Configuration strap inputs
  input wire logic [15:0] portZeroIn,
  output logic bootMode,
  output logic bidirResetActive,
  // Extension bus decode
  input wire logic [23:0] xbusAddr,
  input wire logic xbusReq,
  output logic xramSel,
  output logic canSel,
  output logic xramEnable,
  output logic canEnable,
  // CAN line routing
  input wire logic canTxIn,
  output logic canRxOut,
  input wire logic port4RxIn,
  input wire logic port8RxIn,
  output logic port4TxOut,
  output logic port4Claim,
  output logic port8TxOut,
  output logic port8Claim
);

  logic [1:0] rstSync_q, rstSync_d;
  logic rstN;
  logic pinMeta_q, pinMeta_d, pinSync_q, pinSync_d;
  logic [PIN_MASK_CYC-1:0] drvHist_q, drvHist_d;
  brxe_seq_e seq_q, seq_d;
  brxe_src_e src_q, src_d;
  logic [SEQ_CNT_W-1:0] cnt_q, cnt_d;
  logic bidirEn_q, bidirEn_d;
  logic xperipheral_enable_q, xperipheral_enable_d;
  logic canSel_q, canSel_d;
  logic drive_q, drive_d;
  logic resetInd_q, resetInd_d;
  brxe_flags_s flags_q, flags_d;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic port4Tx_q, port4Tx_d, port8Tx_q, port8Tx_d;
  logic canRx_q, canRx_d;
  logic sysRst_q, sysRst_d;
  logic extReq, busWrite, seqDone, bidirSeq, stayIdle;

  // Reset release through two flops; assertion stays asynchronous, release follows the clock
  always_comb begin
    rstSync_d = {rstSync_q[0], 1'b1};
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= rstSync_d;
    end
  end
  // Everything below runs on the synchronised copy
  assign rstN = rstSync_q[1];

  // Pin synchroniser; first stage feeds only the second
  always_comb begin
    pinMeta_d = resetPinIn;
    pinSync_d = pinMeta_q;
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      pinMeta_q <= 1'b1;
      pinSync_q <= 1'b1;
    end else begin
      pinMeta_q <= pinMeta_d;
      pinSync_q <= pinSync_d;
    end
  end

  // Our own drive echoes back through the synchroniser, so it is masked for that delay
  assign extReq = !pinSync_q && !drive_q && (drvHist_q == '0);
  assign busWrite = wbCyc && wbStb && wbWe && ack_q;
  // Counter starts at zero, so the last cycle of the sequence is one below its length
  assign seqDone = (cnt_q == SEQ_CNT_W'(RESET_SEQ_CYC - 1));
  assign bidirSeq = bidirEn_q;

  always_comb begin
    seq_d = seq_q;
    src_d = src_q;
    cnt_d = cnt_q;
    bidirEn_d = bidirEn_q;
    xperipheral_enable_d = xperipheral_enable_q;
    canSel_d = canSel_q;
    drive_d = drive_q;
    resetInd_d = resetInd_q;
    flags_d = flags_q;
    // Own-drive history, shifted every cycle
    drvHist_d = {drvHist_q[PIN_MASK_CYC-2:0], drive_q};
    unique case (seq_q)
      SEQ_IDLE: begin
        if (extReq || swResetReq || wdtResetReq) begin
          seq_d = SEQ_RUN;
          cnt_d = '0;
          src_d = extReq ? SRC_HW : (wdtResetReq ? SRC_WDT : SRC_SW);
          resetInd_d = 1'b0;
          // Latched mode decides pin drive and flag policy for this sequence
          drive_d = bidirEn_q;
          bidirEn_d = 1'b0;
          xperipheral_enable_d = 1'b0;
          canSel_d = 1'b0;
          // Flags describe the latest reset only
          flags_d = '0;
        end
      end
      SEQ_RUN: begin
        cnt_d = cnt_q + SEQ_CNT_W'(1);
        if (seqDone) begin
          drive_d = 1'b0;
          if (drive_q) begin
            flags_d.longHw = 1'b1;
          end else begin
            // Pin level at the end tells a short pulse from a held one
            unique case (src_q)
              SRC_HW: begin
                flags_d.longHw = !pinSync_q;
                flags_d.shortHw = pinSync_q;
              end
              SRC_SW: flags_d.sw = 1'b1;
              SRC_WDT: flags_d.wdt = 1'b1;
              default: flags_d.longHw = 1'b1;
            endcase
          end
          if (drive_q || src_q == SRC_HW) begin
            flags_d.portZero = portZeroIn;
            flags_d.bootMode = !portZeroIn[BOOT_SEL_BIT];
          end
          // Without bidirectional mode a held external reset keeps the core in reset
          seq_d = (!drive_q && src_q == SRC_HW && !pinSync_q) ? SEQ_HOLD : SEQ_IDLE;
        end
      end
      SEQ_HOLD: begin
        // Leave only once the pin reads high again
        if (pinSync_q) begin
          seq_d = SEQ_IDLE;
        end
      end
      default: seq_d = SEQ_IDLE;
    endcase
    // A reset request in the same cycle wins over end of init and register writes
    stayIdle = (seq_q == SEQ_IDLE) && (seq_d == SEQ_IDLE);
    sysRst_d = (seq_d == SEQ_IDLE);
    if (stayIdle && !resetInd_q && endOfInitExec) begin
      resetInd_d = 1'b1;
      flags_d.initDone = 1'b1;
    end
    if (busWrite && stayIdle && wbAdr == SYS_CFG_OFS && wbSel[0] && !flags_q.initDone) begin
      bidirEn_d = wbDatI[BIDIR_EN_BIT];
      xperipheral_enable_d = wbDatI[XPERIPHERAL_ENABLE_BIT];
    end
    // Pin routing may change at any time outside a sequence
    if (busWrite && stayIdle && wbAdr == CAN_CFG_OFS && wbSel[0]) begin
      canSel_d = wbDatI[CAN_SEL_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      seq_q <= SEQ_IDLE;
      src_q <= SRC_HW;
      cnt_q <= '0;
      bidirEn_q <= SYS_CFG_RESET[BIDIR_EN_BIT];
      xperipheral_enable_q <= SYS_CFG_RESET[XPERIPHERAL_ENABLE_BIT];
      canSel_q <= 1'b0;
      drive_q <= 1'b0;
      resetInd_q <= 1'b0;
      flags_q <= '0;
      drvHist_q <= '0;
      sysRst_q <= 1'b1;
    end else begin
      seq_q <= seq_d;
      src_q <= src_d;
      cnt_q <= cnt_d;
      bidirEn_q <= bidirEn_d;
      xperipheral_enable_q <= xperipheral_enable_d;
      canSel_q <= canSel_d;
      drive_q <= drive_d;
      resetInd_q <= resetInd_d;
      flags_q <= flags_d;
      drvHist_q <= drvHist_d;
      sysRst_q <= sysRst_d;
    end
  end

  // Wishbone slave: ack one cycle after request, write lands on the ack edge
  always_comb begin
    ack_d = wbCyc && wbStb && !ack_q;
    rdata_d = rdata_q;
    // Read data is captured with the ack so it stands through the whole ack cycle
    if (ack_d) begin
      rdata_d = 32'h0000_0000;
      unique case (wbAdr)
        SYS_CFG_OFS: begin
          rdata_d[BIDIR_EN_BIT] = bidirEn_q;
          rdata_d[XPERIPHERAL_ENABLE_BIT] = xperipheral_enable_q;
        end
        CAN_CFG_OFS: rdata_d[CAN_SEL_BIT] = canSel_q;
        STATUS_OFS: begin
          rdata_d[ST_LONG_HW_BIT] = flags_q.longHw;
          rdata_d[ST_SHORT_HW_BIT] = flags_q.shortHw;
          rdata_d[ST_SW_BIT] = flags_q.sw;
          rdata_d[ST_WDT_BIT] = flags_q.wdt;
          rdata_d[ST_BOOT_BIT] = flags_q.bootMode;
          rdata_d[ST_INIT_DONE_BIT] = flags_q.initDone;
          rdata_d[ST_P0_LSB +: 16] = flags_q.portZero;
        end
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // CAN lines registered both ways; only the selected port carries them, idle level otherwise
  always_comb begin
    port4Tx_d = 1'b1;
    port8Tx_d = 1'b1;
    canRx_d = 1'b1;
    if (xperipheral_enable_q && !canSel_q) begin
      port4Tx_d = canTxIn;
      canRx_d = port4RxIn;
    end
    if (xperipheral_enable_q && canSel_q) begin
      port8Tx_d = canTxIn;
      canRx_d = port8RxIn;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      port4Tx_q <= 1'b1;
      port8Tx_q <= 1'b1;
      canRx_q <= 1'b1;
    end else begin
      port4Tx_q <= port4Tx_d;
      port8Tx_q <= port8Tx_d;
      canRx_q <= canRx_d;
    end
  end

  assign wbAck = ack_q;
  assign wbDatO = rdata_q;
  // Open drain: only ever pull low, never drive high
  assign resetPinOut = 1'b0;
  assign resetPinOe_n = !drive_q;
  assign resetIndOut_n = resetInd_q;
  assign sysReset_n = sysRst_q;
  assign bootMode = flags_q.bootMode;
  assign bidirResetActive = bidirSeq;
  // Both extension modules share the one enable
  assign xramEnable = xperipheral_enable_q;
  assign canEnable = xperipheral_enable_q;
  // Address windows decode only while the modules are enabled
  assign xramSel = xperipheral_enable_q && xbusReq && ((xbusAddr & EXTENSION_RAM_MASK) == EXTENSION_RAM_BASE);
  assign canSel = xperipheral_enable_q && xbusReq && ((xbusAddr & CAN_MASK) == CAN_BASE);
  // A disabled module leaves every port pin to its other functions
  assign port4Claim = xperipheral_enable_q && !canSel_q;
  assign port8Claim = xperipheral_enable_q && canSel_q;
  assign canRxOut = canRx_q;
  assign port4TxOut = port4Tx_q;
  assign port8TxOut = port8Tx_q;

endmodule : brxe_top
`default_nettype wire

/* File: verification/brxe_checker.sv */
// Port-level assertions for the reset sequencer
`timescale 1ns/100ps
`default_nettype none
module brxe_checker (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sysReset_n,
  input wire logic resetIndOut_n,
  input wire logic resetPinOe_n,
  input wire logic endOfInitExec,
  input wire logic bidirResetActive,
  input wire logic xramEnable,
  input wire logic canEnable,
  input wire logic xbusReq,
  input wire logic xramSel,
  input wire logic canSel,
  input wire logic port4Claim,
  input wire logic port8Claim
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  pin_in_seq_a: assert property (!resetPinOe_n |-> !sysReset_n)
    else $error("pin pulled outside sequence");
  pin_stretch_a: assert property ($fell(resetPinOe_n) |-> !resetPinOe_n [*8])
    else $error("pin pull too short");
  ind_on_seq_a: assert property ($fell(sysReset_n) |-> !resetIndOut_n)
    else $error("indicator high in sequence");
  ind_rise_a: assert property ($rose(resetIndOut_n) |-> $past(endOfInitExec))
    else $error("indicator rose without end of init");
  mode_clear_a: assert property ($fell(sysReset_n) |-> !bidirResetActive && !xramEnable)
    else $error("enables kept over reset");
  mode_lock_a: assert property (resetIndOut_n && $past(resetIndOut_n) |-> $stable(bidirResetActive))
    else $error("mode bit changed after init");
  xperipheral_enable_freeze_a: assert property (resetIndOut_n && $past(resetIndOut_n) |-> $stable(xramEnable))
    else $error("enable changed after init");
  en_pair_a: assert property (xramEnable == canEnable)
    else $error("enables differ");
  extension_ram_gate_a: assert property (xramSel |-> xramEnable && xbusReq)
    else $error("ram decoded while off");
  can_gate_a: assert property (canSel || port4Claim || port8Claim |-> canEnable)
    else $error("can active while off");
  claim_excl_a: assert property (!(port4Claim && port8Claim))
    else $error("both ports claimed");
  cover property ($fell(resetPinOe_n));
  cover property ($rose(resetIndOut_n));
  cover property (xramSel);
endmodule : brxe_checker
bind brxe_top brxe_checker brxe_checker_inst (.mclk, .reset_n, .sysReset_n, .resetIndOut_n, .resetPinOe_n,
  .endOfInitExec, .bidirResetActive, .xramEnable, .canEnable, .xbusReq, .xramSel, .canSel, .port4Claim,
  .port8Claim);
`default_nettype wire

/* File: verification/brxe_rst_ext.sv */
// External open-drain reset source with pull-up on the reset pin
`timescale 1ns/100ps
`default_nettype none
module brxe_rst_ext (
  input wire logic mclk,
  input wire logic go,
  input wire logic [10:0] pulseLen,
  input wire logic devOe_n,
  output logic pinLevel
);
  logic [10:0] cnt_q = 11'h0;
  always_ff @(posedge mclk) begin
    if (go)
      cnt_q <= pulseLen;
    else if (cnt_q != 11'h0)
      cnt_q <= cnt_q - 11'h1;
  end
  // Only ever pulls low; a released line floats to the pull-up
  assign pinLevel = !((cnt_q != 11'h0) || !devOe_n);
endmodule : brxe_rst_ext
`default_nettype wire

/* File: verification/tb.sv */
// Testbench: register access and reset-sequence scenarios
`timescale 1ns/100ps
`default_nettype none
module tb;
  import brxe_pkg::*;
  logic mclk = 1'b0, reset_n, req, wbWe, wbAck, resetPinIn, resetPinOut, resetPinOe_n, resetIndOut_n;
  logic sysReset_n, swResetReq, wdtResetReq, endOfInitExec, bootMode, bidirResetActive, xbusReq, xramSel;
  logic canSel, xramEnable, canEnable, canTxIn, canRxOut, port4RxIn, port8RxIn, port4TxOut, port4Claim;
  logic port8TxOut, port8Claim, go, pm;
  logic [7:0] wbAdr;
  logic [31:0] wbDatI, wbDatO, q;
  logic [15:0] portZeroIn;
  logic [23:0] xbusAddr;
  logic [10:0] pulseLen;
  int nMismatch = 0, nCompared = 0, n;
  localparam logic [31:0] LONG = 32'h1 << ST_LONG_HW_BIT;
  always #2.5 mclk = ~mclk;
  brxe_top brxe_top_inst (.mclk, .reset_n, .wbCyc(req), .wbStb(req), .wbWe, .wbAdr, .wbSel(4'hf), .wbDatI,
    .wbDatO, .wbAck, .resetPinIn, .resetPinOut, .resetPinOe_n, .resetIndOut_n, .sysReset_n, .swResetReq,
    .wdtResetReq, .endOfInitExec, .portZeroIn, .bootMode, .bidirResetActive, .xbusAddr, .xbusReq, .xramSel,
    .canSel, .xramEnable, .canEnable, .canTxIn, .canRxOut, .port4RxIn, .port8RxIn, .port4TxOut, .port4Claim,
    .port8TxOut, .port8Claim);
  brxe_rst_ext brxe_rst_ext_inst (.mclk, .go, .pulseLen, .devOe_n(resetPinOe_n), .pinLevel(resetPinIn));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    nCompared++;
    if (s !== e) begin
      nMismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  // Request held until the rising edge where ack is seen high; data taken and request dropped there
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int t;
    t = 0;
    @(posedge mclk);
    req <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatI <= d;
    do @(posedge mclk); while (wbAck !== 1'b1 && ++t < 20);
    r = wbDatO;
    req <= 1'b0;
    chk(32'(t < 20), 32'h1);
  endtask : bus
  // 0 software, 1 watchdog, 2 end of init, 3 external pin
  task automatic pulse(input int k);
    @(posedge mclk);
    swResetReq <= (k == 0);
    wdtResetReq <= (k == 1);
    endOfInitExec <= (k == 2);
    go <= (k == 3);
    @(posedge mclk);
    {swResetReq, wdtResetReq, endOfInitExec, go} <= 4'h0;
  endtask : pulse
  task automatic seq(output int c, output logic p);
    int t;
    t = 0;
    c = 0;
    p = 1'b1;
    while (sysReset_n !== 1'b0 && t++ < 20) @(negedge mclk);
    while (sysReset_n === 1'b0 && c < 3000) begin
      if (c == 500)
        p = resetPinIn;
      c++;
      @(negedge mclk);
    end
  endtask : seq
  task complete_run;
    $display("compared %0d mismatched %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  initial begin
    #60000;
    nMismatch++;
    complete_run();
  end
  initial begin
    {reset_n, req, wbWe, swResetReq, wdtResetReq, endOfInitExec, go, xbusReq} = 8'h0;
    {wbAdr, wbDatI, xbusAddr} = 64'h0;
    {canTxIn, port4RxIn, port8RxIn} = 3'b101;
    portZeroIn = 16'h00ef;
    pulseLen = 11'h8;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    bus(0, 8'hfc, 32'h0, q);
    chk(q, 32'h0);
    bus(1, SYS_CFG_OFS, 32'h6, q);
    bus(0, SYS_CFG_OFS, 32'h0, q);
    chk(q, 32'h6);
    xbusReq <= 1'b1;
    xbusAddr <= EXTENSION_RAM_BASE;
    @(negedge mclk);
    chk(32'({xramSel, xramEnable, canEnable}), 32'h7);
    @(posedge mclk);
    xbusAddr <= CAN_BASE;
    @(negedge mclk);
    chk(32'({canSel, xramSel, bidirResetActive}), 32'h5);
    for (int s = 0; s < 2; s++) begin
      bus(1, CAN_CFG_OFS, 32'(s), q);
      canTxIn <= 1'b0;
      repeat (2) @(negedge mclk);
      chk(32'({port8Claim, port4Claim, port8TxOut, port4TxOut, canRxOut}), s ? 32'h13 : 32'h0c);
      @(posedge mclk);
      canTxIn <= 1'b1;
    end
    // Short external pull must still give a full-length sequence
    pulse(3);
    seq(n, pm);
    chk(32'(n), 32'(RESET_SEQ_CYC));
    chk(32'(pm), 32'h0);
    bus(0, STATUS_OFS, 32'h0, q);
    chk(q, LONG | 32'h1 << ST_BOOT_BIT | 32'(portZeroIn) << ST_P0_LSB);
    bus(0, SYS_CFG_OFS, 32'h0, q);
    chk(q, 32'h0);
    chk(32'({bootMode, canSel, port4Claim, resetIndOut_n}), 32'h8);
    bus(1, SYS_CFG_OFS, 32'h2, q);
    pulse(2);
    @(negedge mclk);
    chk(32'(resetIndOut_n), 32'h1);
    bus(1, SYS_CFG_OFS, 32'h4, q);
    bus(0, SYS_CFG_OFS, 32'h0, q);
    chk(q, 32'h2);
    portZeroIn <= 16'h0010;
    for (int k = 0; k < 2; k++) begin
      pulse(k);
      seq(n, pm);
      chk(32'(n), 32'(RESET_SEQ_CYC));
      chk(32'(pm), 32'h0);
      chk(32'(resetPinOut), 32'h0);
      bus(0, STATUS_OFS, 32'h0, q);
      chk(q, LONG | 32'(portZeroIn) << ST_P0_LSB);
      repeat (20) @(negedge mclk);
      chk(32'(sysReset_n), 32'h1);
      bus(1, SYS_CFG_OFS, 32'h2, q);
    end
    // Mid-run reset clears the mode; a short pull then runs without pin drive
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    bus(0, SYS_CFG_OFS, 32'h0, q);
    chk(q, 32'h0);
    chk(32'(resetIndOut_n), 32'h0);
    pulse(3);
    seq(n, pm);
    chk(32'(n), 32'(RESET_SEQ_CYC));
    chk(32'(pm), 32'h1);
    bus(0, STATUS_OFS, 32'h0, q);
    chk(q, 32'h1 << ST_SHORT_HW_BIT | 32'(portZeroIn) << ST_P0_LSB);
    complete_run();
  end
endmodule : tb
`default_nettype wire
